// File: vtu_unit.sv
// Viewport transform unit: clip attribute interpolation, divide, viewport map.
//
// Operation
// - Vertices inside the clip volume keep their colors unchanged.
// - A clipped vertex color is t times first color plus (1-t) second.
// - Index or each RGBA channel is scaled; primary and secondary alike.
// - New vertices come from the given edge endpoints, one plane at a time.
// - Texture, fog, shader outputs and point size interpolate like colors.
// - Screen-linear outputs use a weight adjusted for window-space linearity.
// - Integer outputs are carried from the first endpoint, never interpolated.
// - Plane readback returns stored coefficients; bad index raises enum error.
// - Normalized coordinates divide by w; y negated for top-left origin.
// - Window x,y are half extent times normalized value plus center.
// - Depth is scale times z plus bias, per symmetric or zero-based mode.
// - Viewport comes from the primitive select when given, else zero.
// - Each vertex is transformed with its own primitive's viewport.
// - Depth block write clamps near/far to [0,1]; checks count and range.
// - Broadcast depth command writes the same pair into every viewport.
// - Depth is given in Q16.16 and as 24-bit fixed, all ones is 1.0.
// - Rect block write stores left,bottom,width,height; checks count and range.
// - Center is corner plus half extent; scale extents are stored extents.
// - Corners clamp to bounds range; extents clamp to the extent limit.
// - Negative width or height raises the invalid-value error.
// - Reset gives default extents, half-extent centers, near 0, far 1.
// - Broadcast rect command writes the same rectangle into every viewport.
// - Clip parameter t is held within 0 to 1 inclusive.
// - Reset gives bottom-left origin and symmetric depth mode.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module vtu_unit (
    input  wire logic                                  clock,
    input  wire logic                                  sys_rst,
    input  wire logic [7:0]                            reg_addr,
    input  wire logic [31:0]                           reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic      [31:0]                           reg_rdata,
    input  wire logic                                  in_valid,
    output logic                                       in_ready,
    input  wire logic                                  in_clipped,
    input  wire logic [16:0]                           in_t,
    input  wire logic signed [31:0]                    in_p1_x,
    input  wire logic signed [31:0]                    in_p1_y,
    input  wire logic signed [31:0]                    in_p1_z,
    input  wire logic signed [31:0]                    in_p1_w,
    input  wire logic signed [31:0]                    in_p2_x,
    input  wire logic signed [31:0]                    in_p2_y,
    input  wire logic signed [31:0]                    in_p2_z,
    input  wire logic signed [31:0]                    in_p2_w,
    input  wire logic [vtu_pkg::NATTR*32-1:0]          in_attr1,
    input  wire logic [vtu_pkg::NATTR*32-1:0]          in_attr2,
    input  wire logic [2:0]                            in_view_sel,
    input  wire logic                                  in_view_sel_en,
    output logic                                       out_valid,
    input  wire logic                                  out_ready,
    output logic signed [31:0]                         out_x,
    output logic signed [31:0]                         out_y,
    output logic signed [31:0]                         out_z,
    output logic [vtu_pkg::ZBITS-1:0]                  out_z_fixed,
    output logic [vtu_pkg::NATTR*32-1:0]               out_attr
);
    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    function automatic logic signed [31:0] vtu_lerp(input logic signed [31:0] a,
                                                    input logic signed [31:0] b,
                                                    input logic [16:0]        t);
        logic signed [49:0] acc;
        acc = $signed({1'b0, t}) * a + $signed({1'b0, vtu_pkg::T_ONE - t}) * b;
        return acc[47:16];
    endfunction : vtu_lerp

    function automatic logic signed [31:0] vtu_clamp(input logic signed [31:0] v,
                                                     input logic signed [31:0] lo,
                                                     input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : vtu_clamp

    function automatic logic signed [31:0] vtu_div(input logic signed [31:0] n,
                                                   input logic signed [31:0] d);
        logic signed [47:0] q;
        q = 48'sh0;
        if (d != 32'sh0) begin
            q = $signed({n, 16'h0000}) / $signed({{16{d[31]}}, d});
        end
        return q[31:0];
    endfunction : vtu_div

    function automatic logic signed [31:0] vtu_mul(input logic signed [31:0] a,
                                                   input logic signed [31:0] b);
        logic signed [63:0] p;
        p = a * b;
        return p[47:16];
    endfunction : vtu_mul

    // ------------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------------
    logic                    ctrl_origin;
    logic                    ctrl_depth;
    logic                    err_val;
    logic                    err_enm;
    logic        [31:0]      arg_first;
    logic signed [31:0]      arg_count;
    logic        [31:0]      plane_sel;
    logic        [31:0]      attr_mode;
    logic signed [31:0]      stage    [vtu_pkg::NVIEW*4];
    logic signed [31:0]      plane    [vtu_pkg::NPLANE*4];
    logic signed [31:0]      vp_left  [vtu_pkg::NVIEW];
    logic signed [31:0]      vp_bot   [vtu_pkg::NVIEW];
    logic signed [31:0]      vp_w     [vtu_pkg::NVIEW];
    logic signed [31:0]      vp_h     [vtu_pkg::NVIEW];
    logic signed [31:0]      dr_near  [vtu_pkg::NVIEW];
    logic signed [31:0]      dr_far   [vtu_pkg::NVIEW];

    wire        wr_ctrl   = reg_wr && (reg_addr == vtu_pkg::OFF_CTRL);
    wire        wr_status = reg_wr && (reg_addr == vtu_pkg::OFF_STATUS);
    wire        wr_first  = reg_wr && (reg_addr == vtu_pkg::OFF_FIRST);
    wire        wr_count  = reg_wr && (reg_addr == vtu_pkg::OFF_COUNT);
    wire        wr_cmd    = reg_wr && (reg_addr == vtu_pkg::OFF_CMD);
    wire        wr_psel   = reg_wr && (reg_addr == vtu_pkg::OFF_PSEL);
    wire        wr_amode  = reg_wr && (reg_addr == vtu_pkg::OFF_AMODE);
    wire        coef_hit  = (reg_addr[7:6] == vtu_pkg::PAGE_COEF) &&
                            (reg_addr[5:2] >= vtu_pkg::COEF_HI) &&
                            (reg_addr[5:2] < vtu_pkg::COEF_HI + 4'h4);
    wire        stage_hit = reg_addr[7:6] == vtu_pkg::PAGE_STAGE;
    wire [1:0]  coef_idx  = 2'(reg_addr[5:2] - vtu_pkg::COEF_HI);
    wire        psel_bad  = plane_sel >= vtu_pkg::NPLANE;
    wire [4:0]  coef_addr = {plane_sel[2:0], coef_idx};

    // ------------------------------------------------------------------
    // Viewport and depth-range commands
    // ------------------------------------------------------------------
    wire                 cmd_rect_blk  = wr_cmd && (reg_wdata == vtu_pkg::CMD_RECT_BLK);
    wire                 cmd_depth_blk = wr_cmd && (reg_wdata == vtu_pkg::CMD_DEPTH_BLK);
    wire                 cmd_rect_all  = wr_cmd && (reg_wdata == vtu_pkg::CMD_RECT_ALL);
    wire                 cmd_depth_all = wr_cmd && (reg_wdata == vtu_pkg::CMD_DEPTH_ALL);
    wire                 cmd_blk       = cmd_rect_blk || cmd_depth_blk;
    wire                 cmd_rect      = cmd_rect_blk || cmd_rect_all;
    wire                 cmd_unknown   = wr_cmd && !cmd_blk && !cmd_rect_all && !cmd_depth_all;
    wire signed [33:0]   first_s       = $signed({2'b00, arg_first});
    wire signed [33:0]   end_s         = first_s + 34'(arg_count);
    wire                 range_bad     = cmd_blk && ((arg_count < 32'sh0) ||
                                         (end_s > 34'(vtu_pkg::NVIEW)));
    wire [vtu_pkg::NVIEW-1:0] in_rng;
    wire [vtu_pkg::NVIEW-1:0] neg_ext;
    wire                 cmd_bad       = range_bad || (cmd_rect && (|neg_ext));
    wire                 rect_we       = cmd_rect && !cmd_bad;
    wire                 depth_we      = (cmd_depth_blk || cmd_depth_all) && !cmd_bad;

    for (genvar gi = 0; gi < vtu_pkg::NVIEW; gi++) begin : g_vp
        localparam logic signed [33:0] IDX = 34'(gi);
        wire        bcast = cmd_rect_all || cmd_depth_all;
        wire [33:0] diff  = IDX - first_s;
        wire [1:0]  src   = bcast ? 2'h0 : diff[1:0];
        assign in_rng[gi]  = bcast || ((IDX >= first_s) && (IDX < end_s));
        assign neg_ext[gi] = in_rng[gi] &&
                             (stage[{src, 2'h2}][31] || stage[{src, 2'h3}][31]);
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                vp_left[gi] <= vtu_pkg::Q_ZERO;
                vp_bot[gi]  <= vtu_pkg::Q_ZERO;
                vp_w[gi]    <= vtu_pkg::DEF_WIDTH;
                vp_h[gi]    <= vtu_pkg::DEF_HEIGHT;
                dr_near[gi] <= vtu_pkg::Q_ZERO;
                dr_far[gi]  <= vtu_pkg::Q_ONE;
            end else if (rect_we && in_rng[gi]) begin
                vp_left[gi] <= vtu_clamp(stage[{src, 2'h0}], vtu_pkg::BOUND_MIN,
                                         vtu_pkg::BOUND_MAX);
                vp_bot[gi]  <= vtu_clamp(stage[{src, 2'h1}], vtu_pkg::BOUND_MIN,
                                         vtu_pkg::BOUND_MAX);
                vp_w[gi]    <= vtu_clamp(stage[{src, 2'h2}], vtu_pkg::Q_ZERO,
                                         vtu_pkg::EXTENT_LIMIT);
                vp_h[gi]    <= vtu_clamp(stage[{src, 2'h3}], vtu_pkg::Q_ZERO,
                                         vtu_pkg::EXTENT_LIMIT);
            end else if (depth_we && in_rng[gi]) begin
                dr_near[gi] <= vtu_clamp(stage[{src, 2'h0}], vtu_pkg::Q_ZERO,
                                         vtu_pkg::Q_ONE);
                dr_far[gi]  <= vtu_clamp(stage[{src, 2'h1}], vtu_pkg::Q_ZERO,
                                         vtu_pkg::Q_ONE);
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes and sticky errors
    // ------------------------------------------------------------------
    wire set_val = cmd_bad;
    wire set_enm = cmd_unknown || ((reg_wr || reg_rd) && coef_hit && psel_bad);
    wire clr_val = wr_status && reg_wdata[vtu_pkg::BIT_ERR_VAL];
    wire clr_enm = wr_status && reg_wdata[vtu_pkg::BIT_ERR_ENM];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_origin <= 1'b0;
            ctrl_depth  <= 1'b0;
            err_val     <= 1'b0;
            err_enm     <= 1'b0;
            arg_first   <= 32'h0000_0000;
            arg_count   <= 32'sh0;
            plane_sel   <= 32'h0000_0000;
            attr_mode   <= vtu_pkg::AMODE_RESET;
        end else begin
            err_val <= set_val || (err_val && !clr_val);
            err_enm <= set_enm || (err_enm && !clr_enm);
            if (wr_ctrl) begin
                ctrl_origin <= reg_wdata[vtu_pkg::BIT_ORIGIN];
                ctrl_depth  <= reg_wdata[vtu_pkg::BIT_DEPTH];
            end
            if (wr_first) begin
                arg_first <= reg_wdata;
            end
            if (wr_count) begin
                arg_count <= $signed(reg_wdata);
            end
            if (wr_psel) begin
                plane_sel <= reg_wdata;
            end
            if (wr_amode) begin
                attr_mode <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < vtu_pkg::NVIEW * 4; i++) begin
                stage[i] <= vtu_pkg::Q_ZERO;
            end
            for (int i = 0; i < vtu_pkg::NPLANE * 4; i++) begin
                plane[i] <= vtu_pkg::Q_ZERO;
            end
        end else begin
            if (reg_wr && stage_hit) begin
                stage[reg_addr[5:2]] <= $signed(reg_wdata);
            end
            if (reg_wr && coef_hit && !psel_bad) begin
                plane[coef_addr] <= $signed(reg_wdata);
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads, data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_addr == vtu_pkg::OFF_CTRL) begin
            rd_mux[vtu_pkg::BIT_ORIGIN] = ctrl_origin;
            rd_mux[vtu_pkg::BIT_DEPTH]  = ctrl_depth;
        end else if (reg_addr == vtu_pkg::OFF_STATUS) begin
            rd_mux[vtu_pkg::BIT_ERR_VAL] = err_val;
            rd_mux[vtu_pkg::BIT_ERR_ENM] = err_enm;
        end else if (reg_addr == vtu_pkg::OFF_FIRST) begin
            rd_mux = arg_first;
        end else if (reg_addr == vtu_pkg::OFF_COUNT) begin
            rd_mux = arg_count;
        end else if (reg_addr == vtu_pkg::OFF_PSEL) begin
            rd_mux = plane_sel;
        end else if (reg_addr == vtu_pkg::OFF_AMODE) begin
            rd_mux = attr_mode;
        end else if (coef_hit && !psel_bad) begin
            rd_mux = plane[coef_addr];
        end else if (stage_hit) begin
            rd_mux = stage[reg_addr[5:2]];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Clip interpolation
    // ------------------------------------------------------------------
    wire [16:0]        t_c  = (in_t > vtu_pkg::T_ONE) ? vtu_pkg::T_ONE : in_t;
    wire signed [49:0] tw1  = $signed({1'b0, t_c}) * in_p1_w;
    wire signed [49:0] tw2  = $signed({1'b0, vtu_pkg::T_ONE - t_c}) * in_p2_w;
    wire signed [49:0] tden = tw1 + tw2;
    wire signed [65:0] tq   = (tden == 50'sh0) ? 66'sh0 :
                              $signed({tw1, 16'h0000}) / $signed(66'(tden));
    // Screen-space weight is t*w1 / (t*w1 + (1-t)*w2), held to [0,1].
    wire [16:0]        t_s  = (tden == 50'sh0) ? t_c :
                              (tq < 66'sh0) ? 17'h0_0000 :
                              (tq > 66'(vtu_pkg::T_ONE)) ? vtu_pkg::T_ONE : tq[16:0];

    // Endpoints are those of the edge as already cut by earlier planes.
    wire signed [31:0] cx = in_clipped ? vtu_lerp(in_p1_x, in_p2_x, t_c) : in_p1_x;
    wire signed [31:0] cy = in_clipped ? vtu_lerp(in_p1_y, in_p2_y, t_c) : in_p1_y;
    wire signed [31:0] cz = in_clipped ? vtu_lerp(in_p1_z, in_p2_z, t_c) : in_p1_z;
    wire signed [31:0] cw = in_clipped ? vtu_lerp(in_p1_w, in_p2_w, t_c) : in_p1_w;

    wire [vtu_pkg::NATTR*32-1:0] attr_res;
    for (genvar gl = 0; gl < vtu_pkg::NATTR; gl++) begin : g_attr
        wire [1:0]         mode = attr_mode[2*gl +: 2];
        wire signed [31:0] a1   = in_attr1[32*gl +: 32];
        wire signed [31:0] a2   = in_attr2[32*gl +: 32];
        wire signed [31:0] ip   = vtu_lerp(a1, a2, (mode == vtu_pkg::MODE_SCREEN) ? t_s : t_c);
        wire signed [31:0] mix  = (mode == vtu_pkg::MODE_FLAT) ? a1 : ip;
        assign attr_res[32*gl +: 32] = in_clipped ? mix : a1;
    end

    // ------------------------------------------------------------------
    // Divide and viewport transform
    // ------------------------------------------------------------------
    // Each vertex carries the selection of the primitive it was sent for.
    wire [1:0]         vi   = in_view_sel_en ? in_view_sel[1:0] : 2'h0;
    wire signed [31:0] sw   = vp_w[vi];
    wire signed [31:0] sh   = vp_h[vi];
    wire signed [31:0] ox   = vp_left[vi] + (sw >>> 1);
    wire signed [31:0] oy   = vp_bot[vi] + (sh >>> 1);
    wire signed [31:0] sn   = dr_near[vi];
    wire signed [31:0] sf   = dr_far[vi];
    wire signed [31:0] xd   = vtu_div(cx, cw);
    wire signed [31:0] yq   = vtu_div(cy, cw);
    wire signed [31:0] yd   = ctrl_origin ? -yq : yq;
    wire signed [31:0] zd   = vtu_div(cz, cw);
    wire signed [31:0] xw   = (vtu_mul(sw, xd) >>> 1) + ox;
    wire signed [31:0] yw   = (vtu_mul(sh, yd) >>> 1) + oy;
    wire signed [31:0] zsc  = ctrl_depth ? (sf - sn) : ((sf - sn) >>> 1);
    wire signed [31:0] zbs  = ctrl_depth ? sn : ((sn + sf) >>> 1);
    wire signed [31:0] zw   = vtu_mul(zsc, zd) + zbs;
    wire signed [31:0] zcl  = vtu_clamp(zw, vtu_pkg::Q_ZERO, vtu_pkg::Q_ONE);
    wire [40:0]        zmul = zcl[16:0] * vtu_pkg::Z_ALL_ONES;
    wire [vtu_pkg::ZBITS-1:0] zf = zmul[39:16];
    wire [vtu_pkg::PL_W-1:0]  res_pl = {attr_res, zf, zw, yw, xw};

    // ------------------------------------------------------------------
    // Output register with one skid entry
    // ------------------------------------------------------------------
    logic [vtu_pkg::PL_W-1:0] out_pl;
    logic [vtu_pkg::PL_W-1:0] skid_pl;
    logic                     skid_valid;
    logic                     next_skid_valid;
    logic                     next_out_valid;
    wire                      acc   = in_valid && in_ready;
    wire                      stall = out_valid && !out_ready;

    always_comb begin
        next_skid_valid = stall ? (skid_valid || acc) : 1'b0;
        next_out_valid  = stall || skid_valid || acc;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_valid  <= 1'b0;
            skid_valid <= 1'b0;
            in_ready   <= 1'b1;
            out_pl     <= '0;
            skid_pl    <= '0;
        end else begin
            out_valid  <= next_out_valid;
            skid_valid <= next_skid_valid;
            in_ready   <= !next_skid_valid;
            if (stall && acc) begin
                skid_pl <= res_pl;
            end
            if (!stall) begin
                out_pl <= skid_valid ? skid_pl : res_pl;
            end
        end
    end

    assign out_x       = out_pl[31:0];
    assign out_y       = out_pl[63:32];
    assign out_z       = out_pl[95:64];
    assign out_z_fixed = out_pl[96 +: vtu_pkg::ZBITS];
    assign out_attr    = out_pl[96 + vtu_pkg::ZBITS +: vtu_pkg::NATTR*32];
endmodule : vtu_unit

// File: vtu_pkg.sv
// Constants, register map and field layout of the viewport transform unit.
package vtu_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NVIEW   = 4;
    localparam int NPLANE  = 8;
    localparam int NATTR   = 8;
    localparam int ZBITS   = 24;
    localparam int PL_W    = 3 * 32 + ZBITS + NATTR * 32;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_FIRST  = 8'h08;
    localparam logic [7:0] OFF_COUNT  = 8'h0C;
    localparam logic [7:0] OFF_CMD    = 8'h10;
    localparam logic [7:0] OFF_PSEL   = 8'h14;
    localparam logic [7:0] OFF_AMODE  = 8'h18;
    localparam logic [1:0] PAGE_COEF  = 2'h2;
    localparam logic [3:0] COEF_HI    = 4'h2;
    localparam logic [1:0] PAGE_STAGE = 2'h1;
    // ------------------------------------------------------------------
    // Fields and codes
    // ------------------------------------------------------------------
    localparam int BIT_ORIGIN  = 0;
    localparam int BIT_DEPTH   = 1;
    localparam int BIT_ERR_VAL = 0;
    localparam int BIT_ERR_ENM = 1;
    localparam logic [31:0] CMD_RECT_BLK  = 32'h0000_0001;
    localparam logic [31:0] CMD_DEPTH_BLK = 32'h0000_0002;
    localparam logic [31:0] CMD_RECT_ALL  = 32'h0000_0003;
    localparam logic [31:0] CMD_DEPTH_ALL = 32'h0000_0004;
    localparam logic [1:0] MODE_PERSP  = 2'h0;
    localparam logic [1:0] MODE_SCREEN = 2'h1;
    localparam logic [1:0] MODE_FLAT   = 2'h2;
    // ------------------------------------------------------------------
    // Fixed-point values, Q16.16
    // ------------------------------------------------------------------
    localparam logic [16:0]        T_ONE        = 17'h1_0000;
    localparam logic signed [31:0] Q_ONE        = 32'h0001_0000;
    localparam logic signed [31:0] Q_ZERO       = 32'h0000_0000;
    localparam logic signed [31:0] BOUND_MIN    = 32'h8000_0000;
    localparam logic signed [31:0] BOUND_MAX    = 32'h7FFF_0000;
    localparam logic signed [31:0] EXTENT_LIMIT = 32'h4000_0000;
    localparam logic signed [31:0] DEF_WIDTH    = 32'h0280_0000;
    localparam logic signed [31:0] DEF_HEIGHT   = 32'h01E0_0000;
    localparam logic [23:0]        Z_ALL_ONES   = 24'hFF_FFFF;
    localparam logic [31:0]        AMODE_RESET  = 32'h0000_0000;
endpackage : vtu_pkg

// File: vtu_sink.sv
// Rasterizer-side model that can stall the unit's output.
`timescale 1ns/1ns
module vtu_sink (input wire logic clock, input wire logic stall, output logic out_ready);
    always_ff @(posedge clock) out_ready <= !stall;
endmodule : vtu_sink

// File: vtu_unit_asserts.sv
// Port checks of the viewport transform unit.
`timescale 1ns/1ns
module vtu_unit_asserts (input wire logic clock, sys_rst, reg_rd, in_valid, in_ready,
    input wire logic in_clipped, out_valid, out_ready, input wire logic [31:0] reg_rdata,
    input wire logic signed [31:0] out_z, input wire logic [23:0] out_z_fixed,
    input wire logic [255:0] in_attr1, in_attr2, out_attr);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire go = in_valid && in_ready && (!out_valid || out_ready);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 0) else $error("rdata");
    AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_attr))
        else $error("hold");
    AST_ISSUE: assert property (go |=> out_valid) else $error("issue");
    AST_REFUSE: assert property ($fell(in_ready) |-> $past(out_valid) && !$past(out_ready))
        else $error("refuse");
    AST_DRAIN: assert property (!in_ready && out_ready |-> ##[1:2] in_ready) else $error("drain");
    AST_PASS: assert property (go && (!in_clipped || in_attr1 == in_attr2) |=>
        out_attr == $past(in_attr1)) else $error("pass");
    AST_ZONE: assert property (out_valid && out_z >= 32'sh1_0000 |-> &out_z_fixed) else $error("z1");
    AST_ZERO: assert property (out_valid && out_z <= 0 |-> out_z_fixed == 0) else $error("z0");
endmodule : vtu_unit_asserts
bind vtu_unit vtu_unit_asserts chk (.clock, .sys_rst, .reg_rd, .in_valid, .in_ready, .in_clipped,
    .out_valid, .out_ready, .reg_rdata, .out_z, .out_z_fixed, .in_attr1, .in_attr2, .out_attr);

// File: test_viewport_transform_unit.sv
// Self-checking bench of the viewport transform unit.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module test_viewport_transform_unit;
    logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, in_valid = 0, in_clipped = 0;
    logic stall = 0, sel_en = 1, in_ready, out_valid, out_ready;
    logic [7:0] reg_addr = 0;
    logic [31:0] w2 = 32'h1_0000;
    logic [31:0] reg_wdata = 0, reg_rdata, px = 0, py = 0, pz = 0, out_x, out_y, out_z, d;
    logic [23:0] out_z_fixed;
    logic [255:0] a1 = 256'h2_0000, a2 = 0, out_attr;
    int errors = 0, num_checks = 0, cyc = 0;
    logic [31:0] rows [3][6] = '{'{0, 0, 0, 32'h0140_0000, 32'h00F0_0000, 32'h8000},
        '{32'h1_0000, 32'h8000, 32'h1_0000, 32'h0280_0000, 32'h0168_0000, 32'h1_0000},
        '{32'hFFFF_0000, 32'hFFFF_0000, 32'hFFFF_0000, 0, 0, 0}};
    vtu_unit uut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .in_valid, .in_ready, .in_clipped, .in_t(17'h0_8000), .in_p1_x(px), .in_p1_y(py),
        .in_p1_z(pz), .in_p1_w(32'h1_0000), .in_p2_x(px), .in_p2_y(py), .in_p2_z(pz),
        .in_p2_w(w2), .in_attr1(a1), .in_attr2(a2), .in_view_sel(3'h1),
        .in_view_sel_en(sel_en), .out_valid, .out_ready, .out_x, .out_y, .out_z,
        .out_z_fixed, .out_attr);
    vtu_sink sink (.clock, .stall, .out_ready);
    always #5 clock = ~clock;
    always @(posedge clock) if (++cyc > 2000) begin errors++; final_report(); end
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock) reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock) reg_rd <= 1'b0;
        @(posedge clock) v = reg_rdata;
    endtask : rd
    task automatic send(input logic [31:0] r [6]);
        px <= r[0];
        py <= r[1];
        pz <= r[2];
        in_valid <= 1'b1;
        do @(posedge clock); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        do @(posedge clock); while (!(out_valid === 1'b1 && out_ready === 1'b1));
        `CHK(out_x, r[3])
        `CHK(out_y, r[4])
        `CHK(out_z, r[5])
    endtask : send
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) send(rows[i]);
        $display("rows done");
        rd(8'h00, d);
        `CHK(d, 32'h0)
        wr(8'h0C, 32'hFFFF_FFFF);
        wr(8'h10, 32'h1);
        wr(8'h10, 32'h5);
        rd(8'h04, d);
        `CHK(d, 32'h3)
        wr(8'h04, 32'h3);
        wr(8'h88, 32'h1234_0000);
        rd(8'h88, d);
        `CHK(d, 32'h1234_0000)
        wr(8'h14, 32'h8);
        rd(8'h88, d);
        `CHK(d, 32'h0)
        rd(8'h04, d);
        `CHK(d, 32'h2)
        send(rows[1]);
        $display("errors done");
        stall <= 1'b1;
        in_clipped <= 1'b1;
        w2 <= 32'h3_0000;
        fork begin repeat (8) @(posedge clock); stall <= 1'b0; end join_none
        for (int m = 0; m < 3; m++) begin
            wr(8'h18, m);
            send(rows[0]);
            d = (m == 1) ? 32'h8000 : (m == 2) ? 32'h2_0000 : 32'h1_0000;
            `CHK(out_attr[31:0], d)
        end
        $display("clip done");
        in_clipped <= 1'b0;
        wr(8'h00, 32'h3);
        send('{32'h1_0000, 32'h8000, 32'h1_0000, 32'h0280_0000, 32'h0078_0000, 32'h1_0000});
        wr(8'h40, 32'h0010_0000);
        wr(8'h08, 32'h1);
        wr(8'h0C, 32'h1);
        wr(8'h10, 32'h1);
        send('{0, 0, 0, 32'h0010_0000, 0, 0});
        sel_en <= 1'b0;
        send('{0, 0, 0, 32'h0140_0000, 32'h00F0_0000, 0});
        $display("modes done");
        final_report();
    end
endmodule : test_viewport_transform_unit
